// ==== common/usc_regs.svh ====
// usc_regs.svh: bus offsets, field positions, reset values and counts of the serial core
// assumes inclusion by bare name; definitions only
`ifndef USC_REGS_SVH
`define USC_REGS_SVH
// byte addresses on the bus, low eight address bits
`define USC_ADDR_DATA 8'h00
`define USC_ADDR_CTRL 8'h04
// mode word fields
`define USC_MODE_PAR_EN 0
`define USC_MODE_PAR_ODD 1
`define USC_MODE_EXT_SYNC 2
`define USC_MODE_SINGLE_SYNC 3
// command word fields
`define USC_CMD_TX_EN 0
`define USC_CMD_DTR 1
`define USC_CMD_RX_EN 2
`define USC_CMD_ERR_RST 4
`define USC_CMD_RTS 5
`define USC_CMD_INT_RST 6
`define USC_CMD_HUNT 7
// status byte fields
`define USC_ST_TX_RDY 0
`define USC_ST_RX_RDY 1
`define USC_ST_TX_EMPTY 2
`define USC_ST_PAR_ERR 3
`define USC_ST_OVR_ERR 4
`define USC_ST_FRM_ERR 5
`define USC_ST_SYNC_DET 6
`define USC_ST_DSR 7
// reset values and character framing
`define USC_CMD_RST 8'h00
`define USC_MODE_RST 8'h00
`define USC_SYNC_RST 8'h00
`define USC_CHAR_BITS 4'd8
`define USC_CHAR_BITS_PAR 4'd9
`define USC_HUNT_LAST 4'd7
`define USC_STATUS_LAG_MAX 5'd16
`endif

// ==== common/usc_pkg.sv ====
// usc_pkg: types shared by the serial core
// assumes nothing beyond a SystemVerilog compiler
package usc_pkg;
  typedef logic [31:0] usc_word_t;
  typedef logic [7:0] usc_byte_t;
  typedef enum logic [1:0] {USC_CFG_MODE, USC_CFG_SYNC1, USC_CFG_SYNC2, USC_CFG_CMD} usc_cfg_t;
  typedef enum logic [1:0] {USC_RX_HUNT, USC_RX_HUNT2, USC_RX_DATA} usc_rx_t;
endpackage

// ==== design/usc_core.sv ====
// usc_core: synchronous serial transceiver core behind an AHB-Lite register slave
// assumes hclk at 20 MHz, bit clocks far slower and asynchronous to hclk
//
// What this block does
// RULE_01 - line marks until transmit enabled and clear-to-send is low, then first char goes
// RULE_02 - each bit leaves on a falling transmit bit clock edge, one per cycle
// RULE_03 - an empty buffer after start makes the sender fill with the sync characters
// RULE_04 - transmitter_empty is raised while filling, cleared by the next host character
// RULE_05 - transmitter_empty rises mid last data bit with nothing queued
// RULE_06 - enter_hunt_bit in internal sync puts the receiver into hunt at any time
// RULE_07 - hunt samples each rising receive clock edge and compares with first sync char
// RULE_08 - double sync also checks next char against second sync, then raises sync_detect
// RULE_09 - internally raised sync_detect clears on every status read
// RULE_10 - external party holds sync_detect high one receive clock cycle for sync
// RULE_11 - parity and overrun flagged in sync mode; framing_error_flag never set
// RULE_12 - command word holds transmit/receive enables, error reset and modem outputs
// RULE_13 - after mode and sync chars every control write replaces the command word
// RULE_14 - after any reset the next control write is the mode word
// RULE_15 - a control read returns the status byte, some bits mirror pins
// RULE_16 - status lags internal state by at most 16 clocks
// RULE_17 - parity mismatch sets parity_error_flag, cleared only by error_reset_bit or internal reset
// RULE_18 - new char before read overwrites, sets overrun, cleared by error_reset_bit
// RULE_19 - framing_error_flag belongs to asynchronous framing only
// RULE_20 - ready status bit means buffer empty; ready pin adds clear-to-send and enable
// RULE_21 - control write right after a sync mode word defines a sync character
// RULE_22 - double sync raises sync_detect mid final bit of the second sync char
// RULE_23 - command and status layouts are fixed and shared by reads and writes
`timescale 1ns/1ps
`include "usc_regs.svh"
module usc_core (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire usc_pkg::usc_word_t haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire usc_pkg::usc_word_t hwdata,
  input wire logic hready,
  output logic hreadyout,
  output usc_pkg::usc_word_t hrdata,
  output logic hresp,
  input wire logic transmit_bit_clock,
  input wire logic receive_bit_clock,
  input wire logic rxd,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic sync_detect_i,
  output logic sync_detect_o,
  output logic sync_detect_oe,
  output logic txd,
  output logic transmitter_ready,
  output logic transmitter_empty,
  output logic rx_ready,
  output logic dtr_n,
  output logic rts_n
);
  import usc_pkg::*;

  // two flop synchronisers for every pin and bit clock
  logic [5:0] pin_s1_ff;
  logic [5:0] pin_s2_ff;
  wire [5:0] pin_raw = {sync_detect_i, dsr_n, cts_n, rxd, receive_bit_clock,
                        transmit_bit_clock};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_ff <= 6'h3F;
      pin_s2_ff <= 6'h3F;
    end else begin
      pin_s1_ff <= pin_raw;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  wire txc_s = pin_s2_ff[0];
  wire rxc_s = pin_s2_ff[1];
  wire rxd_s = pin_s2_ff[2];
  wire cts_n_s = pin_s2_ff[3];
  wire dsr_n_s = pin_s2_ff[4];
  wire syn_in_s = pin_s2_ff[5];

  // bit clock edge finders on the synchronised clocks
  logic txc_d_ff;
  logic rxc_d_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txc_d_ff <= 1'b1;
      rxc_d_ff <= 1'b1;
    end else begin
      txc_d_ff <= txc_s;
      rxc_d_ff <= rxc_s;
    end
  end
  wire tx_fall = txc_d_ff & ~txc_s;
  wire tx_rise = ~txc_d_ff & txc_s;
  wire rx_rise = ~rxc_d_ff & rxc_s;

  // bus slave: address phase captured, one wait cycle, then data phase ends
  logic dph_ff;
  logic dwr_ff;
  logic dhit_ff;
  logic [7:0] dadr_ff;
  logic hreadyout_ff;
  usc_word_t hrdata_ff;
  wire take = hsel & hready & htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_ff <= 1'b0;
      dwr_ff <= 1'b0;
      dhit_ff <= 1'b0;
      dadr_ff <= 8'h00;
      hreadyout_ff <= 1'b1;
    end else begin
      dph_ff <= take;
      hreadyout_ff <= ~take;
      if (take) begin
        dwr_ff <= hwrite;
        dhit_ff <= (haddr[31:8] == 24'h000000);
        dadr_ff <= haddr[7:0];
      end
    end
  end

  // access decode during the wait cycle of the data phase
  wire acc = dph_ff & dhit_ff;
  wire wr_data = acc & dwr_ff & (dadr_ff == `USC_ADDR_DATA);
  wire wr_ctrl = acc & dwr_ff & (dadr_ff == `USC_ADDR_CTRL);
  wire rd_data = acc & ~dwr_ff & (dadr_ff == `USC_ADDR_DATA);
  wire rd_stat = acc & ~dwr_ff & (dadr_ff == `USC_ADDR_CTRL); // see RULE_15
  wire [7:0] wbyte = hwdata[7:0];

  // control word sequencer: mode, sync chars, then commands
  usc_cfg_t cfg_ff;
  usc_byte_t mode_ff;
  usc_byte_t sync1_ff;
  usc_byte_t sync2_ff;
  usc_byte_t cmd_ff;
  wire cmd_wr = wr_ctrl & (cfg_ff == USC_CFG_CMD);
  wire soft_rst = cmd_wr & wbyte[`USC_CMD_INT_RST];
  wire err_clr = cmd_wr & wbyte[`USC_CMD_ERR_RST];
  wire cmd_hunt = cmd_wr & wbyte[`USC_CMD_HUNT] & ~soft_rst;
  wire single = mode_ff[`USC_MODE_SINGLE_SYNC];
  wire ext = mode_ff[`USC_MODE_EXT_SYNC];
  wire par_en = mode_ff[`USC_MODE_PAR_EN];
  wire par_odd = mode_ff[`USC_MODE_PAR_ODD];
  wire transmit_enable_bit = cmd_ff[`USC_CMD_TX_EN];
  wire rxen = cmd_ff[`USC_CMD_RX_EN];
  wire [3:0] nbits = par_en ? `USC_CHAR_BITS_PAR : `USC_CHAR_BITS;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_ff <= USC_CFG_MODE;
      mode_ff <= `USC_MODE_RST;
      sync1_ff <= `USC_SYNC_RST;
      sync2_ff <= `USC_SYNC_RST;
      cmd_ff <= `USC_CMD_RST;
    end else if (wr_ctrl) begin
      case (cfg_ff)
        USC_CFG_MODE: begin
          mode_ff <= wbyte; // see RULE_14
          cfg_ff <= USC_CFG_SYNC1; // see RULE_21
        end
        USC_CFG_SYNC1: begin
          sync1_ff <= wbyte;
          cfg_ff <= single ? USC_CFG_CMD : USC_CFG_SYNC2;
        end
        USC_CFG_SYNC2: begin
          sync2_ff <= wbyte;
          cfg_ff <= USC_CFG_CMD;
        end
        USC_CFG_CMD: begin
          if (soft_rst) begin
            cfg_ff <= USC_CFG_MODE; // see RULE_14
            cmd_ff <= `USC_CMD_RST;
          end else begin
            cmd_ff <= wbyte; // see RULE_13 see RULE_12
          end
        end
        default: cfg_ff <= USC_CFG_MODE;
      endcase
    end
  end

  // transmit holding buffer; a host write wins over the shifter taking it
  usc_byte_t tx_buf_ff;
  logic tx_full_ff;
  logic [8:0] tx_sh_ff;
  logic [3:0] tx_cnt_ff;
  logic tx_act_ff;
  logic tx_sidx_ff;
  logic txd_ff;
  logic tx_empty_ff;
  wire tx_bound = tx_act_ff & (tx_cnt_ff == 4'd0);
  wire tx_start = ~tx_act_ff & transmit_enable_bit & ~cts_n_s & tx_full_ff; // see RULE_01
  wire tx_load = tx_fall & (tx_start | (tx_bound & transmit_enable_bit));
  wire tx_stop = tx_fall & tx_bound & ~transmit_enable_bit;
  wire tx_take = tx_load & tx_full_ff;
  wire [7:0] fill_char = (~single & tx_sidx_ff) ? sync2_ff : sync1_ff;
  wire [7:0] tx_char = tx_full_ff ? tx_buf_ff : fill_char; // see RULE_03
  wire tx_par = par_en & (^tx_char ^ par_odd);
  wire [8:0] tx_frame = {tx_par, tx_char};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_buf_ff <= 8'h00;
      tx_full_ff <= 1'b0;
    end else begin
      if (wr_data) tx_buf_ff <= wbyte;
      if (wr_data) tx_full_ff <= 1'b1;
      else if (tx_take | soft_rst) tx_full_ff <= 1'b0;
    end
  end

  // transmit shifter, one bit per falling bit clock edge, lsb first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_sh_ff <= 9'h000;
      tx_cnt_ff <= 4'h0;
      tx_act_ff <= 1'b0;
      tx_sidx_ff <= 1'b0;
      txd_ff <= 1'b1;
    end else if (soft_rst | tx_stop) begin
      tx_act_ff <= 1'b0; // back to marking
      tx_cnt_ff <= 4'h0;
      tx_sidx_ff <= 1'b0;
      txd_ff <= 1'b1;
    end else if (tx_load) begin
      txd_ff <= tx_frame[0]; // see RULE_02
      tx_sh_ff <= {1'b0, tx_frame[8:1]};
      tx_cnt_ff <= nbits - 4'd1;
      tx_act_ff <= 1'b1;
      tx_sidx_ff <= tx_full_ff ? 1'b0 : (~single & ~tx_sidx_ff); // see RULE_03
    end else if (tx_fall & tx_act_ff) begin
      txd_ff <= tx_sh_ff[0]; // see RULE_02
      tx_sh_ff <= {1'b0, tx_sh_ff[8:1]};
      tx_cnt_ff <= tx_cnt_ff - 4'd1;
    end
  end

  // empty flag: set mid last bit with nothing queued, host write clears it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tx_empty_ff <= 1'b1;
    else if (soft_rst) tx_empty_ff <= 1'b1;
    else if (tx_rise & tx_bound & ~tx_full_ff) tx_empty_ff <= 1'b1; // see RULE_05
    else if (wr_data) tx_empty_ff <= 1'b0; // see RULE_04
  end

  // receiver: hunt, optional second sync check, then character assembly
  usc_rx_t rx_st_ff;
  logic [8:0] rx_sh_ff;
  logic [3:0] rx_cnt_ff;
  usc_byte_t rx_buf_ff;
  logic rx_rdy_ff;
  logic pe_ff;
  logic oe_ff;
  logic syn_ff;
  wire [8:0] rx_nsh = {rxd_s, rx_sh_ff[8:1]};
  wire [7:0] hunt_win = rx_nsh[8:1];
  wire in_hunt = rx_rise & (rx_st_ff == USC_RX_HUNT);
  wire hunt_hit = in_hunt & ~ext & (hunt_win == sync1_ff); // see RULE_07
  wire ext_hit = in_hunt & ext & syn_in_s; // see RULE_10
  wire h2_end = rx_rise & (rx_st_ff == USC_RX_HUNT2) & (rx_cnt_ff == `USC_HUNT_LAST);
  wire h2_ok = h2_end & (hunt_win == sync2_ff); // see RULE_08
  wire syn_set = (hunt_hit & single) | h2_ok; // see RULE_22
  wire rx_done = rx_rise & (rx_st_ff == USC_RX_DATA) & (rx_cnt_ff == nbits - 4'd1);
  wire [7:0] rx_char = par_en ? rx_nsh[7:0] : rx_nsh[8:1];
  wire rx_bad = par_en & (rx_nsh[8] != (^rx_nsh[7:0] ^ par_odd));
  wire rx_keep = rx_done & rxen;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st_ff <= USC_RX_HUNT;
      rx_sh_ff <= 9'h000;
      rx_cnt_ff <= 4'h0;
    end else if (soft_rst | cmd_hunt) begin
      rx_st_ff <= USC_RX_HUNT; // see RULE_06
      rx_cnt_ff <= 4'h0;
    end else if (rx_rise) begin
      rx_sh_ff <= rx_nsh;
      case (rx_st_ff)
        USC_RX_HUNT: begin
          if (hunt_hit | ext_hit) begin
            rx_st_ff <= (~ext & ~single) ? USC_RX_HUNT2 : USC_RX_DATA; // see RULE_08
          end
          rx_cnt_ff <= 4'h0;
        end
        USC_RX_HUNT2: begin
          if (h2_end) rx_st_ff <= h2_ok ? USC_RX_DATA : USC_RX_HUNT;
          rx_cnt_ff <= h2_end ? 4'h0 : rx_cnt_ff + 4'd1;
        end
        USC_RX_DATA: rx_cnt_ff <= rx_done ? 4'h0 : rx_cnt_ff + 4'd1;
        default: rx_st_ff <= USC_RX_HUNT;
      endcase
    end
  end

  // received character and its flags; a hardware set wins over a clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_buf_ff <= 8'h00;
      rx_rdy_ff <= 1'b0;
    end else begin
      if (rx_keep) rx_buf_ff <= rx_char; // see RULE_18
      if (rx_keep) rx_rdy_ff <= 1'b1;
      else if (rd_data | soft_rst) rx_rdy_ff <= 1'b0;
    end
  end

  // error flags survive operation until error reset or internal reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pe_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      if (rx_keep & rx_bad) pe_ff <= 1'b1; // see RULE_17 see RULE_11
      else if (err_clr | soft_rst) pe_ff <= 1'b0;
      if (rx_keep & rx_rdy_ff & ~rd_data) oe_ff <= 1'b1; // see RULE_18 see RULE_11
      else if (err_clr | soft_rst) oe_ff <= 1'b0;
    end
  end

  // internal sync detect, cleared by status read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) syn_ff <= 1'b0;
    else if (syn_set) syn_ff <= 1'b1; // see RULE_08
    else if (rd_stat | soft_rst) syn_ff <= 1'b0; // see RULE_09
  end

  // status byte assembled in the shared field layout
  logic [7:0] stat_nxt;
  always_comb begin
    stat_nxt = 8'h00;
    stat_nxt[`USC_ST_TX_RDY] = ~tx_full_ff; // see RULE_20
    stat_nxt[`USC_ST_RX_RDY] = rx_rdy_ff;
    stat_nxt[`USC_ST_TX_EMPTY] = tx_empty_ff;
    stat_nxt[`USC_ST_PAR_ERR] = pe_ff;
    stat_nxt[`USC_ST_OVR_ERR] = oe_ff;
    stat_nxt[`USC_ST_FRM_ERR] = 1'b0; // no stop bit in sync framing, see RULE_19 see RULE_11
    stat_nxt[`USC_ST_SYNC_DET] = ext ? syn_in_s : syn_ff;
    stat_nxt[`USC_ST_DSR] = ~dsr_n_s; // see RULE_23
  end

  // status snapshot lags by one clock, well inside the allowed lag
  usc_byte_t stat_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) stat_ff <= 8'h01;
    else stat_ff <= stat_nxt; // see RULE_16
  end

  // read data mux; unmapped addresses read zero
  wire [31:0] rd_mux = rd_data ? {24'h000000, rx_buf_ff} :
                       rd_stat ? {24'h000000, stat_ff} : 32'h00000000;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata_ff <= 32'h00000000;
    else if (dph_ff & ~dwr_ff) hrdata_ff <= rd_mux;
  end

  // registered pins
  logic tx_rdy_pin_ff;
  logic dtr_n_ff;
  logic rts_n_ff;
  logic syn_oe_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_rdy_pin_ff <= 1'b0;
      dtr_n_ff <= 1'b1;
      rts_n_ff <= 1'b1;
      syn_oe_ff <= 1'b0;
    end else begin
      tx_rdy_pin_ff <= ~tx_full_ff & ~cts_n_s & transmit_enable_bit; // see RULE_20
      dtr_n_ff <= ~cmd_ff[`USC_CMD_DTR]; // see RULE_12
      rts_n_ff <= ~cmd_ff[`USC_CMD_RTS];
      syn_oe_ff <= ~ext & (cfg_ff == USC_CFG_CMD);
    end
  end

  // output drive
  assign hreadyout = hreadyout_ff;
  assign hrdata = hrdata_ff;
  assign hresp = 1'b0;
  assign txd = txd_ff;
  assign transmitter_ready = tx_rdy_pin_ff;
  assign transmitter_empty = tx_empty_ff;
  assign rx_ready = rx_rdy_ff;
  assign sync_detect_o = syn_ff;
  assign sync_detect_oe = syn_oe_ff;
  assign dtr_n = dtr_n_ff;
  assign rts_n = rts_n_ff;
endmodule // usc_core

// ==== tb/usc_assertions.sv ====
// usc_assertions: port-level checks of usc_core, bound to every instance
// assumes one AHB-Lite slave whose hreadyout is the bus hready
`timescale 1ns/1ps
module usc_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire usc_pkg::usc_word_t haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire usc_pkg::usc_word_t hrdata,
  input wire logic hresp,
  input wire logic transmit_bit_clock,
  input wire logic receive_bit_clock,
  input wire logic cts_n,
  input wire logic sync_detect_o,
  input wire logic txd,
  input wire logic transmitter_ready,
  input wire logic transmitter_empty,
  input wire logic dtr_n,
  input wire logic rts_n
);
  import usc_pkg::*;
  logic txc_ff, rxc_ff;
  logic [3:0] tx_age_ff, rx_age_ff;
  // transfer decode
  wire take = hsel && hready && htrans[1];
  wire rd_take = take && !hwrite;
  wire st_rd = rd_take && haddr == 32'h4;
  wire ctl_wr = take && hwrite && haddr == 32'h4;
  wire dat_wr = take && hwrite && haddr == 32'h0;
  wire [3:0] nxt_tx_age = (txc_ff && !transmit_bit_clock) ? 4'h0 : tx_age_ff + {3'h0, tx_age_ff != 4'hF};
  wire [3:0] nxt_rx_age = (!rxc_ff && receive_bit_clock) ? 4'h0 : rx_age_ff + {3'h0, rx_age_ff != 4'hF};
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // cycles since the bit clocks last fell (transmit) or rose (receive)
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txc_ff <= 1'b1;
      rxc_ff <= 1'b0;
      tx_age_ff <= 4'hF;
      rx_age_ff <= 4'hF;
    end else begin
      txc_ff <= transmit_bit_clock;
      rxc_ff <= receive_bit_clock;
      tx_age_ff <= nxt_tx_age;
      rx_age_ff <= nxt_rx_age;
    end
  end
  a_one_wait: assert property (take |=> !hreadyout ##1 hreadyout)
    else $error("transfer without exactly one wait state");
  a_resp_okay: assert property (hreadyout |-> !hresp)
    else $error("response not okay");
  a_upper_zero: assert property ($past(rd_take, 2) |-> hrdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_frame_zero: assert property ($past(st_rd, 2) |-> !hrdata[5])
    else $error("framing flag set");
  a_txd_on_fall: assert property ($fell(txd) |-> tx_age_ff inside {[1:5]})
    else $error("serial out moved away from a transmit clock fall");
  a_sync_on_rise: assert property ($rose(sync_detect_o) |-> rx_age_ff inside {[1:6]})
    else $error("sync detect rose away from a receive clock rise");
  a_sync_clear: assert property (st_rd |-> ##3 !sync_detect_o)
    else $error("sync detect not cleared by status read");
  a_modem_pins: assert property ($changed(dtr_n) || $changed(rts_n) |->
    $past(ctl_wr, 2) || $past(ctl_wr, 3))
    else $error("modem pins moved without a control write");
  a_empty_fall: assert property ($fell(transmitter_empty) |->
    $past(dat_wr, 2) || $past(dat_wr, 3))
    else $error("transmitter empty fell without a data write");
  a_ready_cts: assert property (cts_n [*5] |-> !transmitter_ready)
    else $error("transmitter ready while clear-to-send inactive");
  c_sync: cover property ($rose(sync_detect_o));
  c_fill: cover property ($rose(transmitter_empty));
  c_status: cover property (st_rd);
endmodule // usc_assertions

bind usc_core usc_assertions chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hreadyout, .hrdata, .hresp, .transmit_bit_clock, .receive_bit_clock, .cts_n, .sync_detect_o,
  .txd, .transmitter_ready, .transmitter_empty, .dtr_n, .rts_n);

// ==== tb/usc_peer.sv ====
// usc_peer: serial partner of usc_core; makes both bit clocks, plays rxd and collects txd
// assumes a 400 ns bit; bit clocks stand still between transfers
`timescale 1ns/1ps
module usc_peer (
  output logic transmit_bit_clock,
  output logic receive_bit_clock,
  output logic rxd,
  input wire logic txd
);
  logic [8:0] ch;
  event got;
  // idle levels
  initial begin
    transmit_bit_clock = 1'b1;
    receive_bit_clock = 1'b0;
    rxd = 1'b1;
  end
  // one bit on rxd with a rising receive edge in its middle
  task automatic bit_out(input logic b);
    rxd = b;
    #200 receive_bit_clock = 1'b1;
    #200 receive_bit_clock = 1'b0;
    rxd = ~b; // a released line shows no stale level
  endtask
  // eight bits, first bit first; the offset keeps edges clear of hclk
  task automatic send8(input logic [7:0] v);
    #7;
    for (int i = 0; i < 8; i++) bit_out(v[i]);
  endtask
  task automatic send9(input logic [31:0] v);
    #7;
    for (int i = 0; i < 9; i++) bit_out(v[i]);
  endtask
  // clock one nine-bit character off txd, sampling late in each bit
  task automatic take();
    #7;
    for (int i = 0; i < 9; i++) begin
      transmit_bit_clock = 1'b0;
      #200 transmit_bit_clock = 1'b1;
      #180 ch[i] = txd;
      #20;
    end
    -> got;
  endtask
endmodule // usc_peer

// ==== tb/usart_sync_mode_core_test.sv ====
// usart_sync_mode_core_test: self-checking bench of usc_core over AHB-Lite and the serial peer
// assumes hclk at 20 MHz and the peer of usc_peer.sv
`timescale 1ns/1ps
module usart_sync_mode_core_test;
  import usc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, cts_n, dsr_n, rd_ph, sd_ext, rx_rdy;
  logic [1:0] htrans;
  usc_word_t haddr, hwdata, hrdata, s;
  logic hreadyout, hresp, txclk, rxclk, rxd, sd_o, sd_oe, txd, tx_rdy, tx_emp, dtr_n, rts_n;
  int n_errors, compares;
  usc_word_t qe[$], qm[$], qt[$];
  usc_byte_t d[4];
  localparam usc_byte_t S1 = 8'h16;
  localparam usc_byte_t S2 = 8'h3C;
  // sync pin: driven by the core in internal mode once the command stage is reached, by the bench's external sync otherwise
  wire sd_line = sd_oe ? sd_o : sd_ext;
  usc_core dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .transmit_bit_clock(txclk),
    .receive_bit_clock(rxclk), .rxd, .cts_n, .dsr_n, .sync_detect_i(sd_line),
    .sync_detect_o(sd_o), .sync_detect_oe(sd_oe), .txd, .transmitter_ready(tx_rdy),
    .transmitter_empty(tx_emp), .rx_ready(rx_rdy), .dtr_n, .rts_n);
  usc_peer peer (.transmit_bit_clock(txclk), .receive_bit_clock(rxclk), .rxd, .txd);
  function automatic usc_word_t lfsr(input usc_word_t v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // character with even parity in bit 8
  function automatic usc_word_t ch9(input usc_byte_t b);
    return {23'h0, ^b, b};
  endfunction
  task automatic conclude();
    if (n_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmp(input usc_word_t got, input usc_word_t exp, input usc_word_t m);
    compares++;
    if ((got & m) !== (exp & m)) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h mask %h", $time, got, exp, m);
    end
  endtask
  task automatic pin(input logic got, input logic exp);
    cmp({31'h0, got}, {31'h0, exp}, 32'h1);
  endtask
  // one single AHB-Lite transfer, waiting on hready in both phases
  task automatic bus(input logic wr, input usc_byte_t a, input usc_byte_t v);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, v};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask
  task automatic rd(input usc_byte_t a, input usc_word_t e, input usc_word_t m);
    qe.push_back(e);
    qm.push_back(m);
    bus(1'b0, a, 8'h00);
  endtask
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // compare each finished read and each collected character with the oldest note
  always @(posedge hclk) begin
    if (rd_ph && hreadyout === 1'b1 && qe.size() > 0) cmp(hrdata, qe.pop_front(), qm.pop_front());
    if (hreadyout === 1'b1) rd_ph = hsel && htrans[1] && !hwrite;
  end
  always @(peer.got) cmp({23'h0, peer.ch}, qt.pop_front(), 32'h1FF);
  // cut a hang short
  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    conclude();
  end
  // main sequence
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, rd_ph, sd_ext} = '0;
    cts_n = 1'b1;
    dsr_n = 1'b0;
    s = 32'hE66A61F5;
    foreach (d[i]) begin
      s = lfsr(s);
      d[i] = s[7:0];
    end
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    pin(txd, 1'b1);
    pin(dtr_n, 1'b1);
    rd(8'h04, 32'h84, 32'hFFFFFFFE);
    rd(8'h08, 32'h0, 32'hFFFFFFFF);
    bus(1'b1, 8'h10, 8'hFF);
    bus(1'b1, 8'h04, 8'h01);
    bus(1'b1, 8'h04, S1);
    bus(1'b1, 8'h04, S2);
    bus(1'b1, 8'h04, 8'h22);
    @(posedge hclk);
    pin(dtr_n, 1'b0);
    pin(rts_n, 1'b0);
    bus(1'b1, 8'h04, 8'hA6);
    peer.send8(8'h4A);
    peer.send8(S1);
    peer.send8(S2);
    repeat (16) @(posedge hclk);
    pin(sd_o, 1'b1);
    rd(8'h04, 32'h40, 32'h60);
    rd(8'h04, 32'h00, 32'h40);
    peer.send9(ch9(d[1]));
    repeat (16) @(posedge hclk);
    pin(rx_rdy, 1'b1);
    rd(8'h00, {24'h0, d[1]}, 32'hFFFFFFFF);
    pin(rx_rdy, 1'b0);
    peer.send9(ch9(d[2]) ^ 32'h100);
    peer.send9(ch9(d[3]));
    repeat (16) @(posedge hclk);
    rd(8'h04, 32'h1A, 32'h3A);
    rd(8'h00, {24'h0, d[3]}, 32'hFF);
    bus(1'b1, 8'h04, 8'h36);
    repeat (16) @(posedge hclk);
    rd(8'h04, 32'h00, 32'h3A);
    bus(1'b1, 8'h00, d[0]);
    pin(tx_emp, 1'b0);
    bus(1'b1, 8'h04, 8'h27);
    repeat (4) @(posedge hclk);
    pin(txd, 1'b1);
    pin(tx_rdy, 1'b0);
    cts_n <= 1'b0;
    rd(8'h04, 32'h0, 32'h1);
    qt.push_back(ch9(d[0]));
    qt.push_back(ch9(S1));
    qt.push_back(ch9(S2));
    peer.take();
    pin(tx_emp, 1'b1);
    pin(tx_rdy, 1'b1);
    repeat (2) peer.take();
    bus(1'b1, 8'h00, d[2]);
    pin(tx_emp, 1'b0);
    qt.push_back(ch9(d[2]));
    peer.take();
    bus(1'b1, 8'h04, 8'h40);
    @(posedge hclk);
    pin(dtr_n, 1'b1);
    bus(1'b1, 8'h04, 8'h08);
    bus(1'b1, 8'h04, S1);
    bus(1'b1, 8'h04, 8'h02);
    @(posedge hclk);
    pin(dtr_n, 1'b0);
    pin(rts_n, 1'b1);
    // external sync with odd parity: pin held high over one whole receive clock cycle
    bus(1'b1, 8'h04, 8'h40);
    bus(1'b1, 8'h04, 8'h0F);
    bus(1'b1, 8'h04, S2);
    bus(1'b1, 8'h04, 8'h04);
    sd_ext <= 1'b1;
    #7 peer.bit_out(1'b1);
    @(posedge hclk);
    sd_ext <= 1'b0;
    peer.send9(ch9(d[2]) ^ 32'h100);
    repeat (16) @(posedge hclk);
    pin(rx_rdy, 1'b1);
    rd(8'h04, 32'h02, 32'h3A);
    rd(8'h00, {24'h0, d[2]}, 32'hFF);
    conclude();
  end
endmodule // usart_sync_mode_core_test
